// file: cbl_cfg.svh
// constants for the configuration bitstream loader
`ifndef CBL_CFG_SVH
`define CBL_CFG_SVH

`define CBL_REG_CTRL        8'h00
`define CBL_REG_STATUS      8'h04
`define CBL_REG_COUNT       8'h08
`define CBL_REG_MEM         8'h0C
`define CBL_CTRL_RECFG_BIT  0

`define CBL_MODE_MSER       3'h0
`define CBL_MODE_MPLO       3'h4
`define CBL_MODE_MPHI       3'h6
`define CBL_MODE_PERI       3'h5
`define CBL_MODE_SLAVE      3'h7

`define CBL_PREAMBLE        4'h2
`define CBL_PRE_W           4
`define CBL_LEN_W           16
`define CBL_MEM_W           32
`define CBL_NORECFG_BIT     31
`define CBL_IO_W            8
`define CBL_IO_OE_LSB       8
`define CBL_SYNC_W          15

`define CBL_CLK_PERIOD_NS   4
`define CBL_INIT_TIME_NS    128
`define CBL_INIT_CYCLES     ((`CBL_INIT_TIME_NS + `CBL_CLK_PERIOD_NS - 1) / `CBL_CLK_PERIOD_NS)
`define CBL_OSC_HALF_NS     500
`define CBL_OSC_HALF_CYCLES (`CBL_OSC_HALF_NS / `CBL_CLK_PERIOD_NS)

`endif

// file: cbl_pkg.sv
// types for the configuration bitstream loader
package cbl_pkg;
	typedef enum logic [2:0] {S_INIT, S_WAIT, S_PRE, S_LEN, S_LOAD, S_USER} cbl_state_t;

	typedef struct packed {
		logic [22:0] zero;
		logic        modeReserved;
		logic        noReconfig;
		logic        done;
		logic [2:0]  mode;
		logic [2:0]  state;
	} cbl_status_t;
endpackage : cbl_pkg

// file: cbl_sync.sv
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module cbl_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					meta[i] <= 1'b0;
					q[i]    <= 1'b0;
				end
				else
				begin
					meta[i] <= d[i];
					q[i]    <= meta[i];
				end
			end
		end
	endgenerate
endmodule : cbl_sync

// file: cbl_osc_div.sv
// internal oscillator: divides clk into the driven configuration clock
`timescale 1ns/1ns
`include "cbl_cfg.svh"
module cbl_osc_div (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic run,
	output logic      tick,
	output logic      clkOut
);
	localparam logic [15:0] HALF_LAST = 16'(`CBL_OSC_HALF_CYCLES - 1);

	logic [15:0] cnt;
	wire         wrap = (cnt == HALF_LAST);

	// stopped oscillator parks low so the first edge seen is a rise
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt    <= 16'h0000;
			clkOut <= 1'b0;
			tick   <= 1'b0;
		end
		else if (!run)
		begin
			cnt    <= 16'h0000;
			clkOut <= 1'b0;
			tick   <= 1'b0;
		end
		else
		begin
			cnt    <= wrap ? 16'h0000 : cnt + 16'h0001;
			clkOut <= wrap ? ~clkOut : clkOut;
			tick   <= wrap & ~clkOut;
		end
	end
endmodule : cbl_osc_div

// file: cbl_loader.sv
// configuration bitstream loader with its register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "cbl_cfg.svh"
// Function
// - after power-up, clear configuration memory and hold user logic idle
// - after initialisation, wait for the reset pin high before configuring
// - shift each received configuration bit into memory like a shift register
// - loading mode comes from three static mode pins; stream format is common
// - decode 000 serial, 100 parallel low, 110 parallel high, 101 peripheral, 111 slave
// - the other three mode codes are reserved and must not be strapped
// - after preamble and exactly the counted bits, release the open-drain done pin
// - loading completes or aborts and restarts; never run partly configured
// - from user operation a return to initialisation and full reload is allowed
// - a loaded reconfiguration-disable bit makes user operation ignore reload requests
// - with reconfiguration disabled only a power cycle allows a new configuration
// - during initialisation and configuration, user pins are pulled up, not driven
// - entering user operation, all user pins switch to their functions together
// - configuration clock is an input in slave mode, driven out only while loading in the other modes
// - master modes pace loading from the internal oscillator alone
// - reset pin clears user flip-flops in operation, aborts and restarts loading
module cbl_loader (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  resetPin_b,
	input  wire logic                  mode_select_bit_zero,
	input  wire logic                  mode_select_bit_one,
	input  wire logic                  mode_select_bit_two,
	input  wire logic                  config_clock_in,
	output logic                       config_clock_out,
	output logic                       config_clock_oe_b,
	input  wire logic                  dataIn,
	input  wire logic [7:0]            dataByte,
	output logic [15:0]                addrOut,
	input  wire logic                  doneIn,
	output logic                       doneOut,
	output logic                       doneOe_b,
	output logic [`CBL_IO_W-1:0]       userIoOut,
	output logic [`CBL_IO_W-1:0]       userIoOe_b,
	output logic                       userPullUp,
	output logic                       userClear,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	localparam logic [7:0] INIT_LAST = 8'(`CBL_INIT_CYCLES - 1);

	cbl_pkg::cbl_state_t     state;
	cbl_pkg::cbl_state_t     nextState;
	cbl_pkg::cbl_status_t    status;
	logic [`CBL_SYNC_W-1:0]  syncQ;
	logic [2:0]              mode;
	logic [7:0]              initCnt;
	logic [`CBL_PRE_W-1:0]   preShift;
	logic [`CBL_LEN_W-1:0]   lenShift;
	logic [3:0]              lenIdx;
	logic [`CBL_LEN_W-1:0]   bitCnt;
	logic [2:0]              bitSel;
	logic [`CBL_MEM_W-1:0]   cfgMem;
	logic                    noReconfig;
	logic                    cfgClkPrev;
	logic                    donePrev;
	logic                    swReconfig;
	logic                    oscTick;
	logic                    oscClk;

	cbl_sync #(.W(`CBL_SYNC_W)) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({resetPin_b, doneIn, config_clock_in, dataIn, mode_select_bit_two,
		         mode_select_bit_one, mode_select_bit_zero, dataByte}),
		.q     (syncQ)
	);

	wire       rstPinHigh = syncQ[14];
	wire       doneSync   = syncQ[13];
	wire       cfgClkSync = syncQ[12];
	wire       dataSync   = syncQ[11];
	wire [2:0] modeSync   = syncQ[10:8];
	wire [7:0] byteSync   = syncQ[7:0] & 8'hFF;

	wire inCfg     = (state == cbl_pkg::S_PRE) || (state == cbl_pkg::S_LEN) || (state == cbl_pkg::S_LOAD);
	wire isSlave   = (mode == `CBL_MODE_SLAVE);
	wire isPar     = (mode == `CBL_MODE_MPLO) || (mode == `CBL_MODE_MPHI);
	wire modeReserved = !((modeSync == `CBL_MODE_MSER) || (modeSync == `CBL_MODE_MPLO) ||
	                      (modeSync == `CBL_MODE_MPHI) || (modeSync == `CBL_MODE_PERI) ||
	                      (modeSync == `CBL_MODE_SLAVE));

	cbl_osc_div u_osc (
		.clk    (clk),
		.rst_b  (rst_b),
		.run    (inCfg && !isSlave),
		.tick   (oscTick),
		.clkOut (oscClk)
	);

	// slave takes the external clock rise, masters the oscillator tick
	wire slaveRise = cfgClkSync & ~cfgClkPrev;
	wire bitStrobe = isSlave ? slaveRise : oscTick;
	// parallel modes walk each byte msb first; stream content is the same
	wire dataBit   = isPar ? byteSync[3'h7 - bitSel] : dataSync;
	wire [`CBL_PRE_W-1:0] preNext = {preShift[`CBL_PRE_W-2:0], dataBit};
	wire [`CBL_LEN_W-1:0] lenNext = {lenShift[`CBL_LEN_W-2:0], dataBit};
	wire doneFall  = donePrev & ~doneSync;
	wire reloadReq = (doneFall || swReconfig) && !noReconfig;
	wire finishing = inCfg && (nextState == cbl_pkg::S_USER);

	always_comb
	begin
		nextState = state;
		case (state)
			cbl_pkg::S_INIT:
				if (initCnt == INIT_LAST)
					nextState = cbl_pkg::S_WAIT;
			cbl_pkg::S_WAIT:
				if (rstPinHigh && !modeReserved)
					nextState = cbl_pkg::S_PRE;
			cbl_pkg::S_PRE:
				if (!rstPinHigh)
					nextState = cbl_pkg::S_INIT;
				else if (bitStrobe && preNext == `CBL_PREAMBLE)
					nextState = cbl_pkg::S_LEN;
			cbl_pkg::S_LEN:
				if (!rstPinHigh)
					nextState = cbl_pkg::S_INIT;
				else if (bitStrobe && lenIdx == 4'hF)
					nextState = (lenNext == 16'h0000) ? cbl_pkg::S_USER : cbl_pkg::S_LOAD;
			cbl_pkg::S_LOAD:
				if (!rstPinHigh)
					nextState = cbl_pkg::S_INIT;
				else if (bitStrobe && bitCnt == 16'h0001)
					nextState = cbl_pkg::S_USER;
			cbl_pkg::S_USER:
				if (reloadReq)
					nextState = cbl_pkg::S_INIT;
			default:
				nextState = cbl_pkg::S_INIT;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state      <= cbl_pkg::S_INIT;
			cfgClkPrev <= 1'b0;
			donePrev   <= 1'b0;
			mode       <= `CBL_MODE_MSER;
		end
		else
		begin
			state      <= nextState;
			cfgClkPrev <= cfgClkSync;
			donePrev   <= doneSync;
			mode       <= (state == cbl_pkg::S_WAIT) ? modeSync : mode;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			initCnt  <= 8'h00;
			preShift <= 4'h0;
			lenShift <= 16'h0000;
			lenIdx   <= 4'h0;
			bitCnt   <= 16'h0000;
			bitSel   <= 3'h0;
			cfgMem   <= 32'h0000_0000;
		end
		else if (state == cbl_pkg::S_INIT || state == cbl_pkg::S_WAIT)
		begin
			initCnt  <= (state == cbl_pkg::S_INIT) ? initCnt + 8'h01 : 8'h00;
			preShift <= 4'h0;
			lenShift <= 16'h0000;
			lenIdx   <= 4'h0;
			bitCnt   <= 16'h0000;
			bitSel   <= 3'h0;
			cfgMem   <= 32'h0000_0000;
		end
		else if (inCfg && bitStrobe && rstPinHigh)
		begin
			bitSel <= bitSel + 3'h1;
			if (state == cbl_pkg::S_PRE)
				preShift <= preNext;
			if (state == cbl_pkg::S_LEN)
			begin
				lenShift <= lenNext;
				lenIdx   <= lenIdx + 4'h1;
				bitCnt   <= lenNext;
			end
			if (state == cbl_pkg::S_LOAD)
			begin
				cfgMem <= {cfgMem[`CBL_MEM_W-2:0], dataBit};
				bitCnt <= bitCnt - 16'h0001;
			end
		end
	end

	// only rst_b (power) clears the lock, so reload stays refused
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			noReconfig <= 1'b0;
		else if (finishing)
			noReconfig <= (state == cbl_pkg::S_LOAD) ? cfgMem[`CBL_NORECFG_BIT - 1] : 1'b0;
	end

	// pins, all registered; user pins flip together from one S_USER state decode
	wire [15:0] addrStep = (mode == `CBL_MODE_MPHI) ? 16'hFFFF : 16'h0001;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			config_clock_out  <= 1'b0;
			config_clock_oe_b <= 1'b1;
			addrOut           <= 16'h0000;
			doneOut           <= 1'b0;
			doneOe_b          <= 1'b0;
			userIoOut         <= 8'h00;
			userIoOe_b        <= 8'hFF;
			userPullUp        <= 1'b1;
			userClear         <= 1'b0;
		end
		else
		begin
			config_clock_out  <= oscClk;
			config_clock_oe_b <= !(inCfg && !isSlave);
			if (!inCfg)
				addrOut <= (modeSync == `CBL_MODE_MPHI) ? 16'hFFFF : 16'h0000;
			else if (isPar && bitStrobe && bitSel == 3'h7)
				addrOut <= addrOut + addrStep;
			doneOut           <= 1'b0;
			doneOe_b          <= (state == cbl_pkg::S_USER);
			userIoOut         <= (state == cbl_pkg::S_USER) ? cfgMem[`CBL_IO_W-1:0] : 8'h00;
			userIoOe_b        <= (state == cbl_pkg::S_USER) ? ~cfgMem[`CBL_IO_OE_LSB +: `CBL_IO_W] : 8'hFF;
			userPullUp        <= (state != cbl_pkg::S_USER);
			userClear         <= (state != cbl_pkg::S_USER) || !rstPinHigh;
		end
	end

	// register slave: write needs address and data together, one at a time
	wire wrTake  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	wire rdTake  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	wire wrCtrl  = (s_axi_awaddr == `CBL_REG_CTRL);
	wire rdKnown = (s_axi_araddr == `CBL_REG_CTRL) || (s_axi_araddr == `CBL_REG_STATUS) ||
	               (s_axi_araddr == `CBL_REG_COUNT) || (s_axi_araddr == `CBL_REG_MEM);

	assign status = '{zero: 23'h0, modeReserved: modeReserved, noReconfig: noReconfig,
	                  done: (state == cbl_pkg::S_USER), mode: mode, state: state};

	wire [31:0] rdMux = (s_axi_araddr == `CBL_REG_STATUS) ? status :
	                    (s_axi_araddr == `CBL_REG_COUNT)  ? {16'h0000, bitCnt} :
	                    (s_axi_araddr == `CBL_REG_MEM)    ? cfgMem : 32'h0000_0000;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			swReconfig    <= 1'b0;
		end
		else
		begin
			s_axi_awready <= wrTake;
			s_axi_wready  <= wrTake;
			swReconfig    <= wrTake && wrCtrl && s_axi_wstrb[0] && s_axi_wdata[`CBL_CTRL_RECFG_BIT];
			if (wrTake)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrCtrl ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end
		else
		begin
			s_axi_arready <= rdTake;
			if (rdTake)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdMux;
				s_axi_rresp  <= rdKnown ? 2'h0 : 2'h2;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	a_init_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_INIT) |=> (cfgMem == 32'h0000_0000) && userClear)
		else $error("memory not cleared in init");
	a_wait_reset: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_WAIT) && !rstPinHigh |=> (state == cbl_pkg::S_WAIT))
		else $error("left wait with reset pin low");
	a_shift_mem: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_LOAD) && bitStrobe && rstPinHigh |=> cfgMem[0] == $past(dataBit))
		else $error("bit not shifted into memory");
	a_mode_held: assert property (@(posedge clk) disable iff (!rst_b)
		inCfg |=> $stable(mode))
		else $error("mode changed during loading");
	a_reserved_stay: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_WAIT) && modeReserved |=> (state == cbl_pkg::S_WAIT))
		else $error("reserved mode started loading");
	a_done_exact: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_LOAD) && bitStrobe && rstPinHigh && bitCnt == 16'h0001
		|=> (state == cbl_pkg::S_USER) ##1 doneOe_b)
		else $error("done not released after last bit");
	a_no_partial: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(state == cbl_pkg::S_USER) |-> bitCnt == 16'h0000 || $past(state) == cbl_pkg::S_LEN)
		else $error("user operation with bits missing");
	a_locked_user: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_USER) && noReconfig |=> (state == cbl_pkg::S_USER))
		else $error("reload accepted while locked");
	a_pins_idle: assert property (@(posedge clk) disable iff (!rst_b)
		(state != cbl_pkg::S_USER) |=> userPullUp && (userIoOe_b == 8'hFF))
		else $error("user pin driven before operation");
	a_clock_dir: assert property (@(posedge clk) disable iff (!rst_b)
		inCfg && isSlave |=> config_clock_oe_b)
		else $error("clock driven in slave mode");
	a_user_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_USER) && !rstPinHigh |=> userClear)
		else $error("user clear missing");

	c_configured: cover property (@(posedge clk) disable iff (!rst_b) $rose(state == cbl_pkg::S_USER));
	c_reloaded: cover property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_USER) ##1 (state == cbl_pkg::S_INIT));
	c_aborted: cover property (@(posedge clk) disable iff (!rst_b)
		(state == cbl_pkg::S_LOAD) ##1 (state == cbl_pkg::S_INIT));
	c_slave_load: cover property (@(posedge clk) disable iff (!rst_b) (state == cbl_pkg::S_LOAD) && isSlave);
endmodule : cbl_loader

// file: cbl_src_model.sv
// behavioural configuration source on the far side of the loader's link
`timescale 1ns/1ns
module cbl_src_model (
	input  wire logic linkPin,
	output logic      srcClk,
	output logic      srcData
);
	// link clock stands still outside frames
	initial
	begin
		srcClk = 1'h0;
		srcData = 1'h1;
	end

	// sends n bits of s msb first; slave: own 32 ns clock, else paced by the device clock
	task send(input logic [63:0] s, input int n, input logic slave);
		#1;
		for (int i = n - 1; i >= 0; i--)
		begin
			srcData = s[i];
			if (slave)
			begin
				#16 srcClk = 1'h1;
				#16 srcClk = 1'h0;
			end
			else
			begin
				@(posedge linkPin);
				@(negedge linkPin);
				// step off the device clock edge before the next bit
				#1;
			end
		end
		// released line, no pull: must not keep showing the last bit
		srcData = ~srcData;
	endtask : send
endmodule : cbl_src_model

// file: cbl_loader_tb.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ns
`include "cbl_cfg.svh"
module cbl_loader_tb;
	logic        clk, rst_b, resetPin_b, tbDoneLow, awvalid, wvalid, bready, arvalid, rready;
	logic [2:0]  modePins;
	logic [7:0]  dataByte, awaddr, araddr;
	logic [31:0] wdata, rd, expMem;
	logic [1:0]  resp;
	logic [63:0] strm;
	int          failures, n_compared, seed, t;
	logic [2:0]  modeTab [8] = '{3'h1, 3'h2, 3'h3, `CBL_MODE_MSER, `CBL_MODE_MPLO, `CBL_MODE_MPHI,
		`CBL_MODE_PERI, `CBL_MODE_SLAVE};
	wire         ccOut, ccOe_b, srcClk, srcData, doneOut, doneOe_b, awready, wready, bvalid, arready, rvalid;
	wire         userPullUp, userClear;
	wire [15:0]  addrOut;
	wire [7:0]   ioOut, ioOe_b;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	// wire levels from all drivers; done released reads high
	wire         linkPin = ccOe_b ? srcClk : ccOut;
	wire         donePin = (doneOe_b ? 1'h1 : doneOut) & ~tbDoneLow;

	cbl_loader cbl_loader_inst (.clk(clk), .rst_b(rst_b), .resetPin_b(resetPin_b),
		.mode_select_bit_zero(modePins[0]), .mode_select_bit_one(modePins[1]), .mode_select_bit_two(modePins[2]),
		.config_clock_in(linkPin), .config_clock_out(ccOut), .config_clock_oe_b(ccOe_b), .dataIn(srcData),
		.dataByte(dataByte), .addrOut(addrOut), .doneIn(donePin), .doneOut(doneOut), .doneOe_b(doneOe_b),
		.userIoOut(ioOut), .userIoOe_b(ioOe_b), .userPullUp(userPullUp), .userClear(userClear),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	cbl_src_model cbl_src_model_inst (.linkPin(linkPin), .srcClk(srcClk), .srcData(srcData));

	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// parallel bus noise; only matters in the byte modes
	always @(posedge clk) dataByte <= 8'($random(seed));

	initial
	begin
		#200000;
		failures++;
		end_of_test;
	end

	task chkReg(input logic [31:0] g, e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chkReg

	task chkPin(input logic [15:0] g, e);
		chkReg({16'h0, g}, {16'h0, e});
	endtask : chkPin

	task endT(input string s);
		$display("test %s done", s);
	endtask : endT

	// each channel released at the edge that takes it; idle edge first so calls never collide
	task axWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		while (!bvalid);
		resp = bresp;
		bready <= 1'h0;
	endtask : axWr

	task axRd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end
		while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask : axRd

	task chkStatus(input logic [31:0] mask, e);
		axRd(`CBL_REG_STATUS);
		chkReg(rd & mask, e);
	endtask : chkStatus

	function automatic logic [63:0] mkStream(input logic [15:0] len, input logic [31:0] d);
		return ({42'h0, 2'h3, `CBL_PREAMBLE, len} << len) | {32'h0, d};
	endfunction : mkStream

	// model: memory cleared, then each data bit enters at bit 0
	task load(input logic [2:0] m, input logic [15:0] len, input logic [31:0] d);
		expMem = 32'h0;
		for (int i = len - 1; i >= 0; i--)
			expMem = {expMem[30:0], d[i]};
		modePins <= m;
		resetPin_b <= 1'h1;
		repeat (50) @(posedge clk);
		cbl_src_model_inst.send(mkStream(len, d), 22 + len, m == `CBL_MODE_SLAVE);
		for (t = 0; t < 400 && doneOe_b !== 1'h1; t++)
			@(posedge clk);
		repeat (2) @(posedge clk);
	endtask : load

	task checkUser(input logic [2:0] m);
		chkPin({doneOe_b, userPullUp, 6'h0, ioOut}, {2'h2, 6'h0, expMem[7:0]});
		chkPin({8'h0, ioOe_b}, {8'h0, ~expMem[15:8]});
		axRd(`CBL_REG_MEM);
		chkReg(rd, expMem);
		axRd(`CBL_REG_COUNT);
		chkReg(rd, 32'h0);
		chkStatus(32'h1FF, {23'h0, 1'h0, expMem[31], 1'h1, m, 3'h5});
	endtask : checkUser

	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		seed = 35;
		failures = 0;
		n_compared = 0;
		{rst_b, resetPin_b, tbDoneLow, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		modePins = `CBL_MODE_SLAVE;
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		chkStatus(32'h7, 32'h0);
		chkPin({userPullUp, userClear, doneOe_b, doneOut, 4'h0, ioOe_b}, 16'hC0FF);
		repeat (40) @(posedge clk);
		chkStatus(32'h7, 32'h1);
		endT("power-up");
		foreach (modeTab[k])
		begin
			modePins <= modeTab[k];
			repeat (4) @(posedge clk);
			resetPin_b <= 1'h1;
			repeat (12) @(posedge clk);
			if (modeTab[k] inside {3'h1, 3'h2, 3'h3})
				chkStatus(32'h107, 32'h101);
			else
			begin
				chkStatus(32'h3F, {26'h0, modeTab[k], 3'h2});
				chkPin({15'h0, ccOe_b}, {15'h0, modeTab[k] == `CBL_MODE_SLAVE});
				if (modeTab[k] == `CBL_MODE_MPLO)
					chkPin(addrOut, 16'h0000);
				if (modeTab[k] == `CBL_MODE_MPHI)
					chkPin(addrOut, 16'hFFFF);
			end
			resetPin_b <= 1'h0;
			repeat (45) @(posedge clk);
		end
		endT("modes");
		load(`CBL_MODE_SLAVE, 16'h20, 32'($random(seed)) & 32'h7FFFFFFF);
		checkUser(`CBL_MODE_SLAVE);
		resetPin_b <= 1'h0;
		repeat (6) @(posedge clk);
		chkPin({15'h0, userClear}, 16'h1);
		resetPin_b <= 1'h1;
		repeat (6) @(posedge clk);
		chkPin({15'h0, userClear}, 16'h0);
		endT("slave load");
		tbDoneLow <= 1'h1;
		repeat (6) @(posedge clk);
		tbDoneLow <= 1'h0;
		chkStatus(32'h7, 32'h0);
		load(`CBL_MODE_MSER, 16'h8, 32'($random(seed)) & 32'hFF);
		checkUser(`CBL_MODE_MSER);
		endT("master serial");
		axWr(`CBL_REG_CTRL, 32'h1);
		chkReg({30'h0, resp}, 32'h0);
		load(`CBL_MODE_SLAVE, 16'h20, 32'($random(seed)) | 32'h80000000);
		checkUser(`CBL_MODE_SLAVE);
		axWr(`CBL_REG_CTRL, 32'h1);
		tbDoneLow <= 1'h1;
		repeat (6) @(posedge clk);
		tbDoneLow <= 1'h0;
		axWr(`CBL_REG_STATUS, 32'h0);
		chkReg({30'h0, resp}, 32'h2);
		chkStatus(32'h87, 32'h85);
		axRd(8'h10);
		chkReg(rd, 32'h0);
		chkReg({30'h0, resp}, 32'h2);
		endT("reconfig lock");
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		repeat (50) @(posedge clk);
		chkStatus(32'hBF, 32'h3A);
		// partial frame: header plus 8 of 32 data bits
		strm = mkStream(16'h20, 32'($random(seed)));
		cbl_src_model_inst.send(strm >> 24, 30, 1'h1);
		repeat (8) @(posedge clk);
		chkPin({userPullUp, doneOe_b, 6'h0, ioOe_b}, 16'h80FF);
		axRd(`CBL_REG_COUNT);
		chkReg(rd, 32'h20 - 32'h8);
		resetPin_b <= 1'h0;
		repeat (8) @(posedge clk);
		axRd(`CBL_REG_MEM);
		chkReg(rd, 32'h0);
		axRd(`CBL_REG_COUNT);
		chkReg(rd, 32'h0);
		load(`CBL_MODE_SLAVE, 16'h10, 32'($random(seed)) & 32'hFFFF);
		checkUser(`CBL_MODE_SLAVE);
		endT("abort");
		end_of_test;
	end
endmodule : cbl_loader_tb
